// [bench/sweep_ctl_monitor.sv]
// Concurrent checks on the ports of sweep_execution_control.
// Bound from the testbench; single clock domain, async active-low reset.
`timescale 1ns/1ps
`include "sweep_cfg.svh"

module sweep_ctl_monitor
(
  // Clock and reset
  input wire logic                     i_sys_clk,
  input wire logic                     i_nrst,
  // Commands and events
  input wire logic                     i_preset,
  input wire logic                     i_hold_req,
  input wire logic                     i_single_req,
  input wire logic                     i_cont_req,
  input wire logic                     i_group_count_wr,
  input wire logic [`GROUP_CNT_W-1:0]  i_group_count_entry,
  input wire logic                     i_sweep_done,
  input wire logic                     i_power_wr,
  input wire logic                     i_slope_wr,
  input wire logic                     i_err_clear,
  // Outputs watched
  input wire logic                     o_sweep_run,
  input wire logic                     o_hold_flag,
  input wire logic                     o_restart,
  input wire logic                     o_group_done,
  input wire logic [`GROUP_CNT_W-1:0]  o_groups_remaining,
  input wire sweep_pkg::run_state_type o_run_state,
  input wire logic signed [`POWER_W-1:0] o_src_power,
  input wire logic                     o_slope_active,
  input wire logic                     o_input_overload_error
);
  import sweep_pkg::*;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  logic idle;
  assign idle = !(i_preset | i_hold_req | i_single_req | i_cont_req | i_group_count_wr);

  // Counted run at its last group, no command pending
  sequence s_last_group;
    o_run_state == RUN_COUNTED && o_groups_remaining == 16'h0001 && i_sweep_done && idle;
  endsequence

  sequence s_mid_group;
    o_run_state == RUN_COUNTED && o_groups_remaining > 16'h0001 && i_sweep_done && idle;
  endsequence

  chk_hold_stop: assert property (
    o_hold_flag |-> !o_sweep_run && o_run_state == RUN_HOLD)
    else $error("hold flag without stopped run");
  chk_hold_enter: assert property (
    i_hold_req && idle == 1'b0 && !(i_preset | i_single_req | i_cont_req | i_group_count_wr)
    |=> o_hold_flag)
    else $error("hold request not taken");
  chk_single_start: assert property (
    i_single_req && !i_preset && !i_group_count_wr
    |=> o_restart && o_run_state == RUN_COUNTED && o_groups_remaining == 16'h0001)
    else $error("single request did not start one group");
  chk_count_restart: assert property (
    i_group_count_wr && !i_preset && i_group_count_entry != 16'h0000
    |=> o_restart && o_groups_remaining == $past(i_group_count_entry))
    else $error("group count write did not restart");
  chk_cont_resume: assert property (
    i_cont_req && !(i_preset | i_group_count_wr | i_single_req)
    |=> o_run_state == RUN_CONT && o_sweep_run)
    else $error("continuous request not honoured");
  chk_group_step: assert property (
    s_mid_group |=> o_groups_remaining == $past(o_groups_remaining) - 16'h0001
    && o_run_state == RUN_COUNTED)
    else $error("remaining groups not decremented");
  chk_last_group: assert property (
    s_last_group |=> o_group_done && o_hold_flag && o_groups_remaining == 16'h0000)
    else $error("last group did not enter hold");
  chk_preset_power: assert property (
    i_preset ##1 !(i_power_wr | i_slope_wr) |=> o_src_power == `PRESET_POWER_CDBM
    && !o_slope_active)
    else $error("preset power or slope wrong");
  chk_err_sticky: assert property (
    o_input_overload_error && !i_err_clear && !i_preset |=> o_input_overload_error)
    else $error("overload error cleared by itself");
endmodule

// [bench/sweep_source_model.sv]
// Sweep engine and RF source model: one sweep per go pulse while running.
// Prompt or slow point spacing; position lines inverted outside points.
`timescale 1ns/1ps

module sweep_source_model
(
  // Clock and control
  input  wire logic        i_sys_clk,
  input  wire logic        i_run,
  input  wire logic        i_go,
  input  wire logic        i_slow,
  input  wire logic [3:0]  i_npts,
  // Sweep events
  output logic             o_start = 1'b0,
  output logic             o_point = 1'b0,
  output logic             o_done  = 1'b0,
  output logic [15:0]      o_pos
);
  logic        busy = 1'b0;
  logic [3:0]  n    = 4'h0;
  logic [2:0]  w    = 3'h0;
  logic [15:0] p    = 16'h0000;

  // Position steps by half a GHz per point
  always @(posedge i_sys_clk)
  begin
    o_start <= 1'b0;
    o_point <= 1'b0;
    o_done  <= 1'b0;
    if (!busy && i_go && i_run)
    begin
      busy    <= 1'b1;
      n       <= i_npts;
      w       <= i_slow ? 3'h7 : 3'h0;
      o_start <= 1'b1;
      p       <= 16'h0000;
    end
    else if (busy && w != 3'h0)
      w <= w - 3'h1;
    else if (busy && n != 4'h0)
    begin
      n       <= n - 4'h1;
      w       <= i_slow ? 3'h7 : 3'h0;
      o_point <= 1'b1;
      p       <= p + 16'h0200;
    end
    else if (busy)
    begin
      busy   <= 1'b0;
      o_done <= 1'b1;
    end
  end

  assign o_pos = o_point ? p : ~p;
endmodule

// [bench/testbench.sv]
// Self-checking bench for sweep_execution_control with a sweep engine model.
// Inputs change on the falling edge; commands are one-cycle pulses.
`timescale 1ns/1ps
`include "sweep_cfg.svh"

module testbench;
  import sweep_pkg::*;

  logic clk = 1'b0, nrst = 1'b0, go = 1'b0, slow = 1'b0, avg_en = 1'b0;
  logic chan = 1'b0, slope_en = 1'b0, st, pt, dn, run, hold, rst_p, gdone, avgc, sact;
  logic [8:0] cmd = 9'h000;
  logic [1:0] addr = 2'h0;
  logic [2:0] pins = 3'h0, err;
  logic [15:0] gc = 16'h0000, factor = 16'h0000, wdata = 16'h0000, pos, rem, rdata;
  logic signed [15:0] pwr = 16'h0000, slope = 16'h0000, src;
  sweep_kind_type kind = SWEEP_RAMP;
  run_state_type rs;
  int n_mismatch = 0, compares = 0;

  always #50 clk = ~clk;

  sweep_source_model u_src (.i_sys_clk(clk), .i_run(run), .i_go(go), .i_slow(slow),
    .i_npts(4'h1), .o_start(st), .o_point(pt), .o_done(dn), .o_pos(pos));

  sweep_execution_control u_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_preset(cmd[0]),
    .i_hold_req(cmd[1]), .i_single_req(cmd[2]), .i_cont_req(cmd[3]),
    .i_group_count_wr(cmd[4]), .i_group_count_entry(gc), .i_sweep_kind(kind),
    .i_avg_en(avg_en), .i_avg_factor(factor), .i_sweep_start(st), .i_sweep_point(pt),
    .i_sweep_pos(pos), .i_sweep_done(dn), .i_set_wr(cmd[5]), .i_set_chan(chan),
    .i_set_addr(addr), .i_set_wdata(wdata), .i_power_wr(cmd[6]), .i_power_val(pwr),
    .i_slope_wr(cmd[7]), .i_slope_en(slope_en), .i_source_power_slope(slope),
    .i_overload_pin(pins[0]), .i_lock_lost_pin(pins[1]), .i_no_signal_pin(pins[2]),
    .i_err_clear(cmd[8]), .o_sweep_run(run), .o_hold_flag(hold), .o_restart(rst_p),
    .o_group_done(gdone), .o_avg_complete(avgc), .o_groups_remaining(rem),
    .o_run_state(rs), .o_set_rdata(rdata), .o_src_power(src), .o_slope_active(sact),
    .o_input_overload_error(err[0]), .o_lock_lost_error(err[1]),
    .o_no_signal_error(err[2]));

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task pulse(input int b);
    @(negedge clk) cmd = 9'h001 << b;
    @(negedge clk) cmd = 9'h000;
  endtask

  // One sweep request; judges whether a group completed
  task sweep(input logic e);
    logic got;
    got = 1'b0;
    @(negedge clk) go = 1'b1;
    @(negedge clk) go = 1'b0;
    repeat (30) @(negedge clk) got = got | gdone;
    chk("group done", e, got);
  endtask

  task t_preset;
    chk("run state", RUN_CONT, rs);
    chk("sweep run", 1'b1, run);
    chk("power", `PRESET_POWER_CDBM, src);
    chk("slope", 1'b0, sact);
    sweep(1'b1);
  endtask

  task t_hold_single;
    pulse(1);
    chk("hold", 1'b1, hold);
    chk("run", 1'b0, run);
    addr = 2'h3;
    wdata = 16'h1234;
    pulse(5);
    @(negedge clk);
    chk("held setting", 16'h1234, rdata);
    sweep(1'b0);
    pulse(2);
    chk("restart", 1'b1, rst_p);
    chk("remaining", 16'h0001, rem);
    sweep(1'b1);
    chk("hold", 1'b1, hold);
  endtask

  task t_counted;
    gc = 16'h0003;
    pulse(4);
    chk("remaining", 16'h0003, rem);
    sweep(1'b1);
    chk("remaining", 16'h0002, rem);
    gc = 16'h0002;
    pulse(4);
    chk("restart", 1'b1, rst_p);
    chk("remaining", 16'h0002, rem);
    sweep(1'b1);
    chk("hold", 1'b0, hold);
    sweep(1'b1);
    chk("hold", 1'b1, hold);
    gc = 16'h0001;
    pulse(4);
    chk("state", RUN_COUNTED, rs);
    pulse(3);
    chk("restart", 1'b0, rst_p);
    chk("state", RUN_CONT, rs);
  endtask

  task t_average;
    factor = 16'h0002;
    avg_en = 1'b1;
    pulse(1);
    pulse(3);
    chk("restart", 1'b1, rst_p);
    sweep(1'b1);
    sweep(1'b1);
    chk("averaged", 1'b0, avgc);
    sweep(1'b1);
    chk("averaged", 1'b1, avgc);
    kind = SWEEP_STEP;
    gc = 16'h0001;
    pulse(4);
    sweep(1'b1);
    chk("averaged", 1'b1, avgc);
    chk("hold", 1'b1, hold);
    kind = SWEEP_LIST;
    pulse(4);
    sweep(1'b1);
    chk("averaged", 1'b1, avgc);
    pulse(3);
  endtask

  task t_coupled;
    addr = 2'h0;
    wdata = 16'hABCD;
    pulse(5);
    addr = 2'h2;
    wdata = 16'h5555;
    pulse(5);
    chan = 1'b1;
    repeat (2) @(negedge clk);
    chk("own setting", 16'h0000, rdata);
    addr = 2'h0;
    repeat (2) @(negedge clk);
    chk("coupled setting", 16'hABCD, rdata);
  endtask

  task t_slope;
    pwr = 16'h0100;
    pulse(6);
    slope = 16'h0064;
    slope_en = 1'b1;
    pulse(7);
    chk("slope on", 1'b1, sact);
    sweep(1'b1);
    chk("sloped power", 16'h0132, src);
    slow = 1'b1;
    @(negedge clk) go = 1'b1;
    @(negedge clk) go = 1'b0;
    repeat (3) @(negedge clk);
    chk("base power", 16'h0100, src);
    repeat (20) @(negedge clk);
    pulse(0);
    @(negedge clk);
    chk("preset power", `PRESET_POWER_CDBM, src);
    chk("slope off", 1'b0, sact);
  endtask

  task t_errors;
    @(negedge clk) pins = 3'h7;
    repeat (8) @(negedge clk);
    pins = 3'h0;
    repeat (8) @(negedge clk);
    chk("errors", 16'h0007, err);
    pulse(8);
    repeat (2) @(negedge clk);
    chk("cleared", 16'h0000, err);
  endtask

  task finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #500_000;
    n_mismatch++;
    finish_test;
  end

  initial
  begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_preset;
    t_hold_single;
    t_counted;
    t_average;
    t_coupled;
    t_slope;
    t_errors;
    finish_test;
  end
endmodule

bind sweep_execution_control sweep_ctl_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_nrst(i_nrst), .i_preset(i_preset), .i_hold_req(i_hold_req),
  .i_single_req(i_single_req), .i_cont_req(i_cont_req),
  .i_group_count_wr(i_group_count_wr), .i_group_count_entry(i_group_count_entry),
  .i_sweep_done(i_sweep_done), .i_power_wr(i_power_wr), .i_slope_wr(i_slope_wr),
  .i_err_clear(i_err_clear), .o_sweep_run(o_sweep_run), .o_hold_flag(o_hold_flag),
  .o_restart(o_restart), .o_group_done(o_group_done),
  .o_groups_remaining(o_groups_remaining), .o_run_state(o_run_state),
  .o_src_power(o_src_power), .o_slope_active(o_slope_active),
  .o_input_overload_error(o_input_overload_error));

// [core/pin_sync.sv]
// Three-stage synchroniser with agreement filter for the receiver level pins.
// Pins are asynchronous to i_sys_clk; the level follows once stages 2 and 3 agree.
`timescale 1ns/1ps
`include "sweep_cfg.svh"

module pin_sync
(
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_nrst,
  // Pins and filtered level
  input  wire logic [`ERR_PINS-1:0] i_pins,
  output logic      [`ERR_PINS-1:0] o_level
);
  import sweep_pkg::*;

  sync_state_type s_q;
  sync_state_type s_d;

  always_comb
  begin
    s_d        = s_q;
    s_d.stage1 = i_pins;
    s_d.stage2 = s_q.stage1;
    s_d.stage3 = s_q.stage2;
    for (int i = 0; i < `ERR_PINS; i++)
    begin
      if (s_q.stage2[i] == s_q.stage3[i])
      begin
        s_d.level[i] = s_q.stage3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;

endmodule

// [core/sweep_execution_control.sv]
// Sweep execution control: hold, single, counted and continuous runs,
// group and averaging completion, coupled channel settings, source power
// with slope, and latched receiver level errors.
// Assumes a sweep engine on i_sys_clk that pulses sweep start, point and done,
// and receiver level pins that are asynchronous.
//
// How it works
// - Hold stops new sweeps; settings still change and apply to held data.
// - Hold drives the hold indicator flag for the operator annotation.
// - Single request restarts, runs exactly one group, then enters hold.
// - A programmed group count runs that many groups, then holds.
// - Writing a group count forces an immediate measurement restart.
// - A group count is accepted in any state; nonzero restarts the counted run, zero holds.
// - Continuous mode sweeps without stopping and is the preset state.
// - A continuous request is honoured from every state.
// - Ramp with averaging is fully averaged after factor plus one groups.
// - Step or list sweep: each sweep is one group, averaging complete each.
// - Coupled settings written on one channel update both channels.
// - Preset sets source power to +10 dBm.
// - Errors stay latched until an explicit clear command.
// - Overload, lock lost and no signal are each raised for a high pin level.
// - Slope adds a signed dB/GHz offset growing with sweep frequency.
// - Each sweep starts at base power, offset ramps as the sweep advances.
// - Preset disables power slope.
`timescale 1ns/1ps
`include "sweep_cfg.svh"

module sweep_execution_control
(
  // Clock and reset
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_nrst,
  // Operator commands, one-cycle pulses
  input  wire logic                         i_preset,
  input  wire logic                         i_hold_req,
  input  wire logic                         i_single_req,
  input  wire logic                         i_cont_req,
  input  wire logic                         i_group_count_wr,
  input  wire logic [`GROUP_CNT_W-1:0]      i_group_count_entry,
  // Averaging and sweep kind
  input  wire sweep_pkg::sweep_kind_type    i_sweep_kind,
  input  wire logic                         i_avg_en,
  input  wire logic [`GROUP_CNT_W-1:0]      i_avg_factor,
  // Sweep engine events
  input  wire logic                         i_sweep_start,
  input  wire logic                         i_sweep_point,
  input  wire logic [`POS_W-1:0]            i_sweep_pos,
  input  wire logic                         i_sweep_done,
  // Channel settings access
  input  wire logic                         i_set_wr,
  input  wire logic                         i_set_chan,
  input  wire logic [`SETTING_ADDR_W-1:0]   i_set_addr,
  input  wire logic [`SETTING_W-1:0]        i_set_wdata,
  // Source power and slope
  input  wire logic                         i_power_wr,
  input  wire logic signed [`POWER_W-1:0]   i_power_val,
  input  wire logic                         i_slope_wr,
  input  wire logic                         i_slope_en,
  input  wire logic signed [`POWER_W-1:0]   i_source_power_slope,
  // Receiver level pins and error clear
  input  wire logic                         i_overload_pin,
  input  wire logic                         i_lock_lost_pin,
  input  wire logic                         i_no_signal_pin,
  input  wire logic                         i_err_clear,
  // Run status
  output logic                              o_sweep_run,
  output logic                              o_hold_flag,
  output logic                              o_restart,
  output logic                              o_group_done,
  output logic                              o_avg_complete,
  output logic [`GROUP_CNT_W-1:0]           o_groups_remaining,
  output sweep_pkg::run_state_type          o_run_state,
  // Settings read back
  output logic [`SETTING_W-1:0]             o_set_rdata,
  // Source drive
  output logic signed [`POWER_W-1:0]        o_src_power,
  output logic                              o_slope_active,
  // Latched errors
  output logic                              o_input_overload_error,
  output logic                              o_lock_lost_error,
  output logic                              o_no_signal_error
);
  import sweep_pkg::*;

  ctl_state_type s_q;
  ctl_state_type s_d;

  // Power-up state: continuous run at preset power, slope off, nothing latched
  localparam ctl_state_type RESET_STATE =
  '{
    run:          RUN_CONT,
    remaining:    `PRESET_GROUP_CNT,
    done_groups:  '0,
    restart:      1'b0,
    group_done:   1'b0,
    avg_complete: 1'b0,
    hold_flag:    1'b0,
    sweep_run:    1'b1,
    settings:     '0,
    set_rdata:    '0,
    base_power:   `PRESET_POWER_CDBM,
    slope:        `PRESET_SLOPE_CDB,
    slope_en:     `PRESET_SLOPE_EN,
    pos:          '0,
    src_power:    `PRESET_POWER_CDBM,
    errors:       '0
  };

  logic [`ERR_PINS-1:0] level;

  // Coupling lookup for a setting index
  function automatic logic is_coupled(input logic [`SETTING_ADDR_W-1:0] addr);
    logic [`SETTING_NUM-1:0] mask;
    mask = `SETTING_NUM'(`SETTING_COUPLED);
    return mask[addr];
  endfunction

  // Groups needed before the trace counts as fully averaged
  function automatic logic [`GROUP_CNT_W-1:0] groups_to_average(
    input sweep_kind_type            kind,
    input logic                      avg_en,
    input logic [`GROUP_CNT_W-1:0]   factor
  );
    logic [`GROUP_CNT_W-1:0] n;
    n = `GROUP_CNT_W'(1);
    if (kind == SWEEP_RAMP && avg_en)
    begin
      n = factor + `GROUP_CNT_W'(1);
    end
    return n;
  endfunction

  pin_sync u_pin_sync
  (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_pins    ({i_no_signal_pin, i_lock_lost_pin, i_overload_pin}),
    .o_level   (level)
  );

  logic signed [2*`POWER_W:0]   slope_prod;
  logic signed [`POWER_W-1:0]   slope_offset;
  logic                         group_end;
  logic [`GROUP_CNT_W-1:0]      need_groups;

  always_comb
  begin
    s_d             = s_q;
    s_d.restart     = 1'b0;
    s_d.group_done  = 1'b0;
    slope_prod      = '0;
    slope_offset    = '0;
    group_end       = 1'b0;
    need_groups     = groups_to_average(i_sweep_kind, i_avg_en, i_avg_factor);

    // A sweep completed while running closes a group in all sweep kinds
    group_end = i_sweep_done && s_q.sweep_run;

    // Run mode selection, preset first
    if (i_preset)
    begin
      s_d.run         = RUN_CONT;
      s_d.remaining   = `PRESET_GROUP_CNT;
      s_d.done_groups = '0;
      s_d.restart     = 1'b1;
    end
    else if (i_group_count_wr)
    begin
      s_d.remaining   = i_group_count_entry;
      s_d.done_groups = '0;
      s_d.restart     = 1'b1;
      if (i_group_count_entry == '0)
      begin
        s_d.run = RUN_HOLD;
      end
      else
      begin
        s_d.run = RUN_COUNTED;
      end
    end
    else if (i_single_req)
    begin
      s_d.run         = RUN_COUNTED;
      s_d.remaining   = `GROUP_CNT_W'(1);
      s_d.done_groups = '0;
      s_d.restart     = 1'b1;
    end
    else if (i_cont_req)
    begin
      s_d.run = RUN_CONT;
      // Leaving hold starts a fresh measurement
      if (s_q.run == RUN_HOLD)
      begin
        s_d.restart     = 1'b1;
        s_d.done_groups = '0;
      end
    end
    else if (i_hold_req)
    begin
      s_d.run = RUN_HOLD;
    end
    // A command in the same cycle takes precedence over a sweep end
    else if (group_end)
    begin
      s_d.group_done = 1'b1;
      if (s_q.done_groups != '1)
      begin
        s_d.done_groups = s_q.done_groups + `GROUP_CNT_W'(1);
      end
      case (s_q.run)
        RUN_COUNTED:
        begin
          s_d.remaining = s_q.remaining - `GROUP_CNT_W'(1);
          if (s_q.remaining <= `GROUP_CNT_W'(1))
          begin
            s_d.remaining = '0;
            s_d.run       = RUN_HOLD;
          end
        end
        RUN_CONT:
        begin
          s_d.run = RUN_CONT;
        end
        RUN_HOLD:
        begin
          s_d.run = RUN_HOLD;
        end
        default:
        begin
          s_d.run = RUN_HOLD;
        end
      endcase
    end

    // No new sweeps in hold; indicator follows the mode
    s_d.sweep_run = (s_d.run != RUN_HOLD);
    s_d.hold_flag = (s_d.run == RUN_HOLD);

    // Averaging completion
    if (s_d.restart)
    begin
      s_d.avg_complete = 1'b0;
    end
    else
    begin
      s_d.avg_complete = (s_d.done_groups >= need_groups);
    end

    // Channel settings; allowed in any mode including hold
    if (i_preset)
    begin
      s_d.settings = '0;
    end
    else if (i_set_wr)
    begin
      s_d.settings[i_set_chan][i_set_addr] = i_set_wdata;
      if (is_coupled(i_set_addr))
      begin
        s_d.settings[~i_set_chan][i_set_addr] = i_set_wdata;
      end
    end
    // Read back lags a write by one edge
    s_d.set_rdata = s_q.settings[i_set_chan][i_set_addr];

    // Base power and slope settings
    if (i_preset)
    begin
      s_d.base_power = `PRESET_POWER_CDBM;
      s_d.slope      = `PRESET_SLOPE_CDB;
      s_d.slope_en   = `PRESET_SLOPE_EN;
    end
    else
    begin
      if (i_power_wr)
      begin
        s_d.base_power = i_power_val;
      end
      if (i_slope_wr)
      begin
        s_d.slope    = i_source_power_slope;
        s_d.slope_en = i_slope_en;
      end
    end

    // Sweep position; a new sweep starts from zero offset
    if (i_sweep_start || s_d.restart)
    begin
      s_d.pos = '0;
    end
    else if (i_sweep_point)
    begin
      s_d.pos = i_sweep_pos;
    end

    // Offset = slope * position, position in 1/1024 GHz
    slope_prod   = s_q.slope * $signed({1'b0, s_q.pos});
    slope_offset = slope_prod[`POS_FRAC_BITS +: `POWER_W];
    if (s_q.slope_en)
    begin
      s_d.src_power = s_q.base_power + slope_offset;
    end
    else
    begin
      s_d.src_power = s_q.base_power;
    end

    // Latched errors: set wins over clear
    if (i_err_clear)
    begin
      s_d.errors = '0;
    end
    s_d.errors = s_d.errors | level;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= RESET_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign o_sweep_run            = s_q.sweep_run;
  assign o_hold_flag            = s_q.hold_flag;
  assign o_restart              = s_q.restart;
  assign o_group_done           = s_q.group_done;
  assign o_avg_complete         = s_q.avg_complete;
  assign o_groups_remaining     = s_q.remaining;
  assign o_run_state            = s_q.run;
  assign o_set_rdata            = s_q.set_rdata;
  assign o_src_power            = s_q.src_power;
  assign o_slope_active         = s_q.slope_en;
  assign o_input_overload_error = s_q.errors[`ERR_OVERLOAD_BIT];
  assign o_lock_lost_error      = s_q.errors[`ERR_LOCK_LOST_BIT];
  assign o_no_signal_error      = s_q.errors[`ERR_NO_SIGNAL_BIT];

endmodule

// [pkg/sweep_cfg.svh]
// Constants for the sweep execution and source power control block.
// Assumes a 10 MHz system clock; included by the package and the modules.
`ifndef SWEEP_CFG_SVH
`define SWEEP_CFG_SVH

// Clock
`define SYS_CLK_HZ          10_000_000

// Data widths
`define GROUP_CNT_W         16
`define SETTING_W           16
`define POWER_W             16
`define POS_W               16
`define ERR_PINS            3

// Settings store
`define CHAN_NUM            2
`define SETTING_NUM         4
`define SETTING_ADDR_W      2
`define SETTING_COUPLED     4'h0003

// Error pin positions
`define ERR_OVERLOAD_BIT    0
`define ERR_LOCK_LOST_BIT   1
`define ERR_NO_SIGNAL_BIT   2

// Preset values: power in 0.01 dBm, slope in 0.01 dB/GHz
`define PRESET_POWER_CDBM   16'h03E8
`define PRESET_SLOPE_CDB    16'h0000
`define PRESET_SLOPE_EN     1'b0
`define PRESET_GROUP_CNT    16'h0000
`define SETTING_RESET       16'h0000

// Sweep position is in units of 1/1024 GHz
`define POS_FRAC_BITS       10

`endif

// [pkg/sweep_pkg.sv]
// Types for the sweep execution and source power control block.
// Relies on sweep_cfg.svh for all widths except those of the two enums.
`include "sweep_cfg.svh"

package sweep_pkg;

  // Run mode, one-hot
  typedef enum logic [2:0]
  {
    RUN_CONT    = 3'b001,
    RUN_HOLD    = 3'b010,
    RUN_COUNTED = 3'b100
  } run_state_type;

  // Sweep kind reported by the stimulus engine
  typedef enum logic [1:0]
  {
    SWEEP_RAMP = 2'b00,
    SWEEP_STEP = 2'b01,
    SWEEP_LIST = 2'b10
  } sweep_kind_type;

  typedef struct packed
  {
    logic [`ERR_PINS-1:0] stage1;
    logic [`ERR_PINS-1:0] stage2;
    logic [`ERR_PINS-1:0] stage3;
    logic [`ERR_PINS-1:0] level;
  } sync_state_type;

  typedef struct packed
  {
    run_state_type                                       run;
    logic [`GROUP_CNT_W-1:0]                             remaining;
    logic [`GROUP_CNT_W-1:0]                             done_groups;
    logic                                                restart;
    logic                                                group_done;
    logic                                                avg_complete;
    logic                                                hold_flag;
    logic                                                sweep_run;
    logic [`CHAN_NUM-1:0][`SETTING_NUM-1:0][`SETTING_W-1:0] settings;
    logic [`SETTING_W-1:0]                               set_rdata;
    logic signed [`POWER_W-1:0]                          base_power;
    logic signed [`POWER_W-1:0]                          slope;
    logic                                                slope_en;
    logic [`POS_W-1:0]                                   pos;
    logic signed [`POWER_W-1:0]                          src_power;
    logic [`ERR_PINS-1:0]                                errors;
  } ctl_state_type;

endpackage
